// >>> logic/wake_defines.svh
// Register offsets, field positions, reset values and timing figures
// for the self-polling preamble wake controller.
// Assumes inclusion by bare name from the design files.
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

// Register offsets on the register port.
`define OFS_PATTERN_LOW 8'h0D
`define OFS_PATTERN_HIGH 8'h0E
`define OFS_PREAMBLE_LENGTH 8'h0F
`define OFS_INTERRUPT_STATUS 8'h13
`define OFS_POWER_STATE_CONTROL 8'h14
`define OFS_DETECT_WINDOW_TIME 8'h17
`define OFS_WAIT_DETECT_RATIO 8'h18

// Field positions.
`define BIT_CRYSTAL_OSC_ENABLE 0
`define BIT_SLAVE_RX_ENABLE 1
`define BIT_POLL_TIMER_ENABLE 2
`define BIT_PREAMBLE_FOUND 0

// Reset values.
`define RST_PATTERN 16'h0000
`define RST_PREAMBLE_LENGTH 4'h0
`define RST_POWER_STATE_CONTROL 3'h0
`define RST_DETECT_WINDOW 8'h00
`define RST_WAIT_RATIO 7'h00

// Timing: one timer tick is 0.08 ms, the window starts at 0.48 ms.
`define CLK_PERIOD_PS 5000
`define TICK_TIME_PS 80000000
`define TICK_CYCLES (`TICK_TIME_PS / `CLK_PERIOD_PS)
`define WINDOW_BASE_TICKS 9'd6

`endif

// >>> logic/wake_pkg.sv
// Types shared by the self-polling preamble wake controller.
// Assumes wake_defines.svh carries the numeric constants.
package wake_pkg;

   typedef enum logic [3:0]
   {
      ST_STANDBY = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_POLL = 4'b0100,
      ST_SLAVE = 4'b1000
   } poll_state_t;

   typedef logic [7:0] reg_byte_t;

endpackage : wake_pkg

// >>> logic/self_polling_preamble_wake.sv
// Self-polling controller with wake-up timer, Manchester preamble
// detector and a DATA pin that doubles as wake interrupt.
// Assumes the register port and symbol stream are synchronous to
// core_clk_i.
//
// Function
// - Poll enable write in standby starts polling
// - Detection window set by 8-bit field
// - Wait equals window times ratio 1..128
// - Period is window plus wait time
// - Match sets flag, DATA low in wait
// - Status read clears flag, enable, to standby
// - Length code selects 1 to 16 bits
// - Pattern LSB is most recent received bit
// - Raw 0 is symbols 10, 1 is 01
// - Match at any alignment of the stream
// - Slave receive puts demodulated stream on DATA
// - DATA high in polling and idle wait
// - Unread status repeats poll and low pulse
// - Clearing receive enable returns to standby
`timescale 1ns/1ps
`include "wake_defines.svh"

module symbol_fifo
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o = mem[rd_ptr_ff];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= wr_ptr_ff + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_ff <= rd_ptr_ff + AW'(1);
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : symbol_fifo

module self_polling_preamble_wake
#(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int FIFO_DEPTH = 16
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Power-down pin, high shuts the block down
   input wire logic power_down_pin_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output wake_pkg::reg_byte_t reg_rdata_o,
   // Demodulated symbol stream
   input wire logic sym_i,
   input wire logic sym_valid_i,
   output logic sym_ready_o,
   // Slave receive pacing, one pulse per DATA bit
   input wire logic data_take_i,
   // DATA pin and state view
   output logic data_o,
   output wake_pkg::poll_state_t state_o
);
   import wake_pkg::*;

   logic rst_meta_ff;
   logic rstn_ff;
   poll_state_t state_ff;
   poll_state_t nxt_state;
   logic [15:0] pattern_ff;
   logic [3:0] length_ff;
   logic [2:0] ctrl_ff;
   logic [7:0] window_ff;
   logic [6:0] ratio_ff;
   logic found_ff;
   logic data_ff;
   reg_byte_t rdata_ff;
   logic [15:0] presc_ff;
   logic [16:0] tick_cnt_ff;
   logic [31:0] shift_ff;
   logic [5:0] fill_ff;
   logic tick;
   logic status_read;
   logic window_done;
   logic wait_done;
   logic match;
   logic [8:0] window_ticks;
   logic [16:0] wait_ticks;
   logic [31:0] expect_sym;
   logic [31:0] mask_sym;
   logic fifo_ready;
   logic fifo_sym;
   logic fifo_valid;
   logic fifo_take;
   logic poll_en;
   logic slave_en;

   // The release is delayed two edges so no flop leaves reset mid-cycle.
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_ff <= 1'b0;
         rstn_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rstn_ff <= rst_meta_ff;
      end
   end

   assign status_read = reg_rd_i && (reg_addr_i == `OFS_INTERRUPT_STATUS);
   assign poll_en = ctrl_ff[`BIT_POLL_TIMER_ENABLE];
   assign slave_en = ctrl_ff[`BIT_SLAVE_RX_ENABLE];

   // Configuration registers; power-down loses them as shutdown does.
   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         pattern_ff <= `RST_PATTERN;
         length_ff <= `RST_PREAMBLE_LENGTH;
         window_ff <= `RST_DETECT_WINDOW;
         ratio_ff <= `RST_WAIT_RATIO;
      end
      else if (power_down_pin_i)
      begin
         pattern_ff <= `RST_PATTERN;
         length_ff <= `RST_PREAMBLE_LENGTH;
         window_ff <= `RST_DETECT_WINDOW;
         ratio_ff <= `RST_WAIT_RATIO;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `OFS_PATTERN_LOW: pattern_ff[7:0] <= reg_wdata_i;
            `OFS_PATTERN_HIGH: pattern_ff[15:8] <= reg_wdata_i;
            `OFS_PREAMBLE_LENGTH: length_ff <= reg_wdata_i[3:0];
            `OFS_DETECT_WINDOW_TIME: window_ff <= reg_wdata_i;
            `OFS_WAIT_DETECT_RATIO: ratio_ff <= reg_wdata_i[6:0];
            default: ;
         endcase
      end
   end

   // Power state control; the status read wins over a same-cycle write.
   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         ctrl_ff <= `RST_POWER_STATE_CONTROL;
      end
      else if (power_down_pin_i)
      begin
         ctrl_ff <= `RST_POWER_STATE_CONTROL;
      end
      else if (status_read)
      begin
         ctrl_ff[`BIT_POLL_TIMER_ENABLE] <= 1'b0;
      end
      else if (reg_wr_i && reg_addr_i == `OFS_POWER_STATE_CONTROL)
      begin
         ctrl_ff <= reg_wdata_i[2:0];
      end
   end

   // Sticky detect flag; a match in the read cycle is kept.
   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         found_ff <= 1'b0;
      end
      else if (power_down_pin_i)
      begin
         found_ff <= 1'b0;
      end
      else if (match)
      begin
         found_ff <= 1'b1;
      end
      else if (status_read)
      begin
         found_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         rdata_ff <= 8'h00;
      end
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            `OFS_PATTERN_LOW: rdata_ff <= pattern_ff[7:0];
            `OFS_PATTERN_HIGH: rdata_ff <= pattern_ff[15:8];
            `OFS_PREAMBLE_LENGTH: rdata_ff <= {4'h0, length_ff};
            `OFS_INTERRUPT_STATUS: rdata_ff <= {7'h00, found_ff};
            `OFS_POWER_STATE_CONTROL: rdata_ff <= {5'h00, ctrl_ff};
            `OFS_DETECT_WINDOW_TIME: rdata_ff <= window_ff;
            `OFS_WAIT_DETECT_RATIO: rdata_ff <= {1'b0, ratio_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // Timer base: one tick per 0.08 ms of core clock.
   assign tick = (presc_ff == 16'(TICK_CYCLES - 1));

   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         presc_ff <= 16'h0000;
      end
      else if (power_down_pin_i || !poll_en || tick)
      begin
         presc_ff <= 16'h0000;
      end
      else
      begin
         presc_ff <= presc_ff + 16'h0001;
      end
   end

   assign window_ticks = {1'b0, window_ff} + `WINDOW_BASE_TICKS;
   assign wait_ticks = 17'(window_ticks) * 17'({1'b0, ratio_ff} + 8'h01);
   // Each end count belongs to its own phase, so the shorter window count
   // cannot cut a wait interval short.
   assign window_done = tick && (state_ff == ST_POLL) &&
                        (tick_cnt_ff == 17'(window_ticks - 9'h001));
   assign wait_done = tick && (state_ff == ST_WAIT) &&
                      (tick_cnt_ff == wait_ticks - 17'h00001);

   // Ticks within the current window or wait phase.
   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         tick_cnt_ff <= 17'h00000;
      end
      else if (power_down_pin_i || !poll_en || window_done || wait_done)
      begin
         tick_cnt_ff <= 17'h00000;
      end
      else if (tick)
      begin
         tick_cnt_ff <= tick_cnt_ff + 17'h00001;
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_STANDBY:
         begin
            if (poll_en)
            begin
               nxt_state = ST_WAIT;
            end
            else if (slave_en)
            begin
               nxt_state = ST_SLAVE;
            end
         end
         ST_WAIT:
         begin
            if (!poll_en)
            begin
               nxt_state = ST_STANDBY;
            end
            else if (state_ff == ST_WAIT && wait_done)
            begin
               nxt_state = ST_POLL;
            end
         end
         ST_POLL:
         begin
            if (!poll_en)
            begin
               nxt_state = ST_STANDBY;
            end
            else if (window_done)
            begin
               nxt_state = ST_WAIT;
            end
         end
         ST_SLAVE:
         begin
            if (!slave_en)
            begin
               nxt_state = ST_STANDBY;
            end
         end
         default: nxt_state = ST_STANDBY;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         state_ff <= ST_STANDBY;
      end
      else if (power_down_pin_i)
      begin
         state_ff <= ST_STANDBY;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Symbols are buffered so a paced DATA pin can hold the source back.
   symbol_fifo
   #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_i(core_clk_i),
      .rstn_i(rstn_ff),
      .in_data_i(sym_i),
      .in_valid_i(sym_valid_i),
      .in_ready_o(fifo_ready),
      .out_data_o(fifo_sym),
      .out_valid_o(fifo_valid),
      .out_ready_i(state_ff != ST_SLAVE || data_take_i)
   );

   assign fifo_take = fifo_valid && (state_ff != ST_SLAVE || data_take_i);

   // Expected symbols: raw 0 arrives as 1 then 0, raw 1 as 0 then 1.
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_enc
         assign expect_sym[2*gi] = pattern_ff[gi];
         assign expect_sym[2*gi+1] = !pattern_ff[gi];
         assign mask_sym[2*gi] = (4'(gi) <= length_ff);
         assign mask_sym[2*gi+1] = (4'(gi) <= length_ff);
      end
   endgenerate

   // Sliding compare on every symbol, so any phase matches.
   assign match = (state_ff == ST_POLL) &&
                  (fill_ff > {1'b0, length_ff, 1'b1}) &&
                  (((shift_ff ^ expect_sym) & mask_sym) == 32'h0);

   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         shift_ff <= 32'h0;
         fill_ff <= 6'h00;
      end
      else if (state_ff != ST_POLL)
      begin
         fill_ff <= 6'h00;
      end
      else if (fifo_take)
      begin
         shift_ff <= {shift_ff[30:0], fifo_sym};
         if (fill_ff != 6'h20)
         begin
            fill_ff <= fill_ff + 6'h01;
         end
      end
   end

   // DATA pin level by state.
   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         data_ff <= 1'b1;
      end
      else
      begin
         case (nxt_state)
            ST_SLAVE:
            begin
               if (fifo_take)
               begin
                  data_ff <= fifo_sym;
               end
            end
            ST_WAIT: data_ff <= !(found_ff || match);
            default: data_ff <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_ff)
   begin
      if (!rstn_ff)
      begin
         sym_ready_o <= 1'b0;
      end
      else
      begin
         sym_ready_o <= fifo_ready && !power_down_pin_i;
      end
   end

   assign data_o = data_ff;
   assign state_o = state_ff;
   assign reg_rdata_o = rdata_ff;

endmodule : self_polling_preamble_wake

// >>> verification/wake_checker.sv
// Port checker for the self-polling wake controller.
// Assumes it is bound onto the top module with its tick parameter.
`timescale 1ns/1ps
module wake_checker
#(
   parameter int TICK_CYCLES = 4
)
(
   // Watched ports
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic power_down_pin_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic sym_ready_o,
   input wire logic data_o,
   input wake_pkg::poll_state_t state_o
);
   import wake_pkg::*;
   logic [7:0] detect_window_field_ff;
   logic [6:0] ratio_ff;
   poll_state_t prev_ff;
   poll_state_t from_ff;
   int run_ff;
   int win;
   assign win = (int'(detect_window_field_ff) + 6) * TICK_CYCLES;
   // Mirrors of the timer fields; power-down clears them like the design.
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         detect_window_field_ff <= 8'h00;
      else if (power_down_pin_i)
         detect_window_field_ff <= 8'h00;
      else if (reg_wr_i && reg_addr_i == 8'h17)
         detect_window_field_ff <= reg_wdata_i;
   end
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ratio_ff <= 7'h00;
      else if (power_down_pin_i)
         ratio_ff <= 7'h00;
      else if (reg_wr_i && reg_addr_i == 8'h18)
         ratio_ff <= reg_wdata_i[6:0];
   end
   // Length of the current state run and the state that preceded it.
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prev_ff <= ST_STANDBY;
         from_ff <= ST_STANDBY;
         run_ff <= 0;
      end
      else
      begin
         prev_ff <= state_o;
         if (state_o != prev_ff)
         begin
            from_ff <= prev_ff;
            run_ff <= 1;
         end
         else
            run_ff <= run_ff + 1;
      end
   end
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   start_by_write_a: assert property (
      state_o == ST_WAIT && prev_ff == ST_STANDBY
      |-> $past(reg_wr_i && reg_addr_i == 8'h14 && reg_wdata_i[2], 2))
      else $error("Polling started without an enable write");
   poll_window_a: assert property (
      prev_ff == ST_POLL && state_o == ST_WAIT |-> run_ff == win)
      else $error("Detection window length is wrong");
   wait_span_a: assert property (
      prev_ff == ST_WAIT && state_o == ST_POLL && from_ff == ST_POLL
      |-> run_ff == win * (int'(ratio_ff) + 1))
      else $error("Wait length is wrong");
   fall_in_wait_a: assert property (
      $fell(data_o) && state_o != ST_SLAVE |-> state_o == ST_WAIT)
      else $error("DATA fell outside a wait interval");
   poll_data_high_a: assert property (
      state_o == ST_POLL |-> data_o)
      else $error("DATA low during polling window");
   read_clears_a: assert property (
      reg_rd_i && reg_addr_i == 8'h13 && state_o != ST_SLAVE
      && !power_down_pin_i ##1 !reg_wr_i
      |=> state_o == ST_STANDBY && data_o)
      else $error("Status read did not return to standby");
   slave_entry_a: assert property (
      state_o == ST_STANDBY && reg_wr_i && reg_addr_i == 8'h14
      && reg_wdata_i[2:1] == 2'b01 && !power_down_pin_i
      |-> ##2 state_o == ST_SLAVE)
      else $error("Receive enable did not enter slave state");
   slave_exit_a: assert property (
      state_o == ST_SLAVE && reg_wr_i && reg_addr_i == 8'h14
      && !reg_wdata_i[1] && !power_down_pin_i |-> ##2 state_o == ST_STANDBY)
      else $error("Clearing receive enable kept the receiver on");
   power_down_a: assert property (
      power_down_pin_i |=> state_o == ST_STANDBY)
      else $error("Power-down did not reset the state");
   wake_cov: cover property (prev_ff == ST_POLL && !data_o);
   slave_cov: cover property (state_o == ST_SLAVE);
   full_cov: cover property ($fell(sym_ready_o) && state_o == ST_SLAVE);
endmodule : wake_checker

bind self_polling_preamble_wake wake_checker
#(
   .TICK_CYCLES(TICK_CYCLES)
)
u_chk
(
   .core_clk_i(core_clk_i),
   .rstn_i(rstn_i),
   .power_down_pin_i(power_down_pin_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .sym_ready_o(sym_ready_o),
   .data_o(data_o),
   .state_o(state_o)
);

// >>> verification/mcu_wake_model.sv
// External controller model that wakes on a falling DATA edge.
// Assumes DATA is sampled on the core clock.
`timescale 1ns/1ps
module mcu_wake_model
(
   // Clock, reset and DATA pin
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic data_i,
   // Wake request towards the bench
   output logic wake_o
);
   logic last_ff;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         last_ff <= 1'b1;
      else
         last_ff <= data_i;
   end
   // A falling edge raises wake_o for one clock cycle.
   assign wake_o = last_ff && !data_i;
endmodule : mcu_wake_model

// >>> verification/testbench.sv
// Self-checking bench for the self-polling preamble wake controller.
// Assumes design, checker and controller model are compiled first.
`timescale 1ns/1ps
module testbench;
   import wake_pkg::*;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic pd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sym = 1'b0;
   logic sym_valid = 1'b0;
   logic take = 1'b0;
   reg_byte_t rdata;
   reg_byte_t got;
   logic sym_ready_o;
   logic data_o;
   logic wake;
   poll_state_t state_o;
   int errors = 0;
   int num_checks = 0;
   int i;
   int k;
   logic [15:0] pat;
   logic [3:0] len;
   logic q[$];
   logic [7:0] ofs [5] = '{8'h0D, 8'h0E, 8'h0F, 8'h17, 8'h18};
   logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h7F};
   always #2.5 core_clk_i = ~core_clk_i;
   self_polling_preamble_wake #(.TICK_CYCLES(4), .FIFO_DEPTH(16)) u_dut
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .power_down_pin_i(pd),
      .reg_addr_i(addr),
      .reg_wdata_i(wdata),
      .reg_wr_i(wr),
      .reg_rd_i(rd),
      .reg_rdata_o(rdata),
      .sym_i(sym),
      .sym_valid_i(sym_valid),
      .sym_ready_o(sym_ready_o),
      .data_take_i(take),
      .data_o(data_o),
      .state_o(state_o)
   );
   mcu_wake_model u_mcu
   (
      .clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .data_i(data_o),
      .wake_o(wake)
   );
   task automatic print_verdict;
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic check_byte(input string nm, input reg_byte_t e,
      input reg_byte_t a);
      num_checks++;
      if (a !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, a);
      end
   endtask : check_byte
   task automatic check_bit(input string nm, input logic e, input logic a);
      num_checks++;
      if (a !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %b got %b", nm, e, a);
      end
   endtask : check_bit
   // Symbol k of the encoded pattern, symbol 0 being the newest one.
   function automatic logic manch_sym(input logic [15:0] p, input int k);
      return k[0] ? !p[k / 2] : p[k / 2];
   endfunction : manch_sym
   task automatic give_up(input int n, input int lim);
      if (n >= lim)
      begin
         errors++;
         print_verdict();
      end
   endtask : give_up
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge core_clk_i);
      wr = 1'b0;
   endtask : reg_write
   task automatic read_check(input string nm, input logic [7:0] a,
      input reg_byte_t e);
      @(negedge core_clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge core_clk_i);
      rd = 1'b0;
      check_byte(nm, e, rdata);
   endtask : read_check
   task automatic wait_state(input poll_state_t st);
      int n;
      for (n = 0; n < 2000 && state_o !== st; n++)
         @(negedge core_clk_i);
      give_up(n, 2000);
      @(negedge core_clk_i);
   endtask : wait_state
   task automatic send_sym(input logic b);
      int n;
      @(negedge core_clk_i);
      for (n = 0; n < 50 && sym_ready_o !== 1'b1; n++)
         @(negedge core_clk_i);
      give_up(n, 50);
      sym = b;
      sym_valid = 1'b1;
      @(posedge core_clk_i);
   endtask : send_sym
   initial
   begin
      void'($urandom(32'hFDFF));
      repeat (3) @(negedge core_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      for (k = 0; k < 5; k++)
         read_check("reset", ofs[k], 8'h00);
      read_check("reset", 8'h14, 8'h00);
      for (k = 0; k < 5; k++)
      begin
         got = 8'($urandom);
         reg_write(ofs[k], got);
         read_check("readback", ofs[k], got & msk[k]);
      end
      reg_write(8'h20, 8'hA5);
      read_check("unmapped", 8'h20, 8'h00);
      for (i = 0; i < 2; i++)
      begin
         len = (i == 0) ? 4'hF : 4'($urandom);
         pat = 16'($urandom);
         reg_write(8'h0D, pat[7:0]);
         reg_write(8'h0E, pat[15:8]);
         reg_write(8'h0F, {4'h0, len});
         reg_write(8'h17, 8'd20);
         reg_write(8'h18, 8'h01);
         reg_write(8'h14, 8'h05);
         wait_state(ST_POLL);
         repeat ($urandom_range(1, 5)) send_sym(1'($urandom));
         for (k = 2 * len + 1; k >= 0; k--)
            send_sym(manch_sym(pat, k));
         @(negedge core_clk_i);
         sym_valid = 1'b0;
         for (k = 0; k < 400 && wake !== 1'b1; k++)
            @(negedge core_clk_i);
         give_up(k, 400);
         check_byte("state", 8'(ST_WAIT), 8'(state_o));
         wait_state(ST_POLL);
         check_bit("data", 1'b1, data_o);
         wait_state(ST_WAIT);
         check_bit("data", 1'b0, data_o);
         read_check("status", 8'h13, 8'h01);
         @(negedge core_clk_i);
         check_byte("state", 8'(ST_STANDBY), 8'(state_o));
         check_bit("data", 1'b1, data_o);
         read_check("control", 8'h14, 8'h01);
      end
      reg_write(8'h14, 8'h05);
      wait_state(ST_POLL);
      wait_state(ST_WAIT);
      check_bit("data", 1'b1, data_o);
      read_check("status", 8'h13, 8'h00);
      reg_write(8'h14, 8'h03);
      wait_state(ST_SLAVE);
      for (k = 0; k < 20; k++)
      begin
         @(negedge core_clk_i);
         if (sym_ready_o !== 1'b1)
            break;
         sym = 1'($urandom);
         sym_valid = 1'b1;
         q.push_back(sym);
         @(negedge core_clk_i);
         sym_valid = 1'b0;
      end
      check_byte("fill", 8'd16, 8'(q.size()));
      while (q.size() > 0)
      begin
         @(negedge core_clk_i);
         take = 1'b1;
         @(negedge core_clk_i);
         take = 1'b0;
         check_bit("data", q.pop_front(), data_o);
      end
      reg_write(8'h14, 8'h01);
      @(negedge core_clk_i);
      check_byte("state", 8'(ST_STANDBY), 8'(state_o));
      reg_write(8'h14, 8'h05);
      wait_state(ST_POLL);
      pd = 1'b1;
      repeat (2) @(negedge core_clk_i);
      pd = 1'b0;
      check_byte("state", 8'(ST_STANDBY), 8'(state_o));
      read_check("window", 8'h17, 8'h00);
      print_verdict();
   end
endmodule : testbench
